// File: hw/ctx_pkg.sv
// Package of constants and types for the continuous transmission test block
package ctx_pkg;
    localparam int CTX_AW = 6;
    localparam int CTX_DW = 8;
    // Register offsets
    localparam logic [5:0] CTX_A_STATE = 6'h01;
    localparam logic [5:0] CTX_A_CMD = 6'h02;
    localparam logic [5:0] CTX_A_MODE = 6'h0c;
    localparam logic [5:0] CTX_A_MASK = 6'h0e;
    localparam logic [5:0] CTX_A_FLAGS = 6'h0f;
    localparam logic [5:0] CTX_A_EN2 = 6'h1c;
    localparam logic [5:0] CTX_A_EN1 = 6'h36;
    // Reset values
    localparam logic [7:0] CTX_R_MODE = 8'h24;
    localparam logic [7:0] CTX_R_EN2 = 8'h07;
    localparam logic [7:0] CTX_R_ZERO = 8'h00;
    // Command and state codes of the state command field
    localparam logic [7:0] CTX_C_TX_START = 8'h02;
    localparam logic [7:0] CTX_C_FORCE_OFF = 8'h03;
    localparam logic [7:0] CTX_C_PLL_ON = 8'h09;
    localparam logic [7:0] CTX_S_OFF = 8'h08;
    localparam logic [7:0] CTX_S_PLL = 8'h09;
    localparam logic [7:0] CTX_S_BUSY_TX = 8'h02;
    // Unlock key values
    localparam logic [7:0] CTX_K_ONE = 8'h0f;
    localparam logic [7:0] CTX_K_TWO = 8'h54;
    localparam logic [7:0] CTX_K_THREE = 8'h46;
    localparam logic [7:0] CTX_K_OFF = 8'h00;
    // Mode select codes
    localparam logic [7:0] CTX_M_BPSK20 = 8'h00;
    localparam logic [7:0] CTX_M_BPSK40 = 8'h04;
    localparam logic [7:0] CTX_M_OQ100 = 8'h08;
    localparam logic [7:0] CTX_M_OQSIN250 = 8'h0c;
    localparam logic [7:0] CTX_M_OQRC250 = 8'h1c;
    localparam logic [7:0] CTX_M_CW_NARROW = 8'h0a;
    localparam logic [7:0] CTX_M_CW_WIDE = 8'h0e;
    // Modulation codes driven to the modulator
    localparam logic [2:0] CTX_MOD_BPSK20 = 3'h0;
    localparam logic [2:0] CTX_MOD_BPSK40 = 3'h1;
    localparam logic [2:0] CTX_MOD_OQ100 = 3'h2;
    localparam logic [2:0] CTX_MOD_OQSIN250 = 3'h3;
    localparam logic [2:0] CTX_MOD_OQRC250 = 3'h4;
    localparam logic [2:0] CTX_MOD_OQ400 = 3'h5;
    localparam logic [2:0] CTX_MOD_OQ1000 = 3'h6;
    // Header and field limits
    localparam logic [6:0] CTX_PHR_MIN = 7'h01;
    localparam int CTX_LOCK_BIT = 0;
    localparam int CTX_UPPER_BIT = 7;
    localparam logic [1:0] CTX_HDR_LAST = 2'h1;

    typedef enum logic [1:0] {CTX_TS_OFF, CTX_TS_PLL, CTX_TS_TX} ctx_trx_t;
    typedef enum logic [1:0] {CTX_PH_IDLE, CTX_PH_HDR, CTX_PH_DATA} ctx_ph_t;
endpackage

// File: hw/ctx_mode_dec.sv
// Decoder of the test mode select code into modulation and carrier settings
`timescale 1ns/1ps
module ctx_mode_dec
    import ctx_pkg::*;
(
    input wire logic [7:0] mode_code,
    output logic mode_ok,
    output logic mode_cw,
    output logic cw_wide,
    output logic [2:0] mod_sel
);
    // Unknown codes are refused so transmission can never start on them
    always_comb begin
        mode_ok = 1'b1;
        mode_cw = 1'b0;
        cw_wide = 1'b0;
        mod_sel = CTX_MOD_BPSK20;
        if (mode_code == CTX_M_BPSK20) begin
            mod_sel = CTX_MOD_BPSK20;
        end else if (mode_code == CTX_M_BPSK40) begin
            mod_sel = CTX_MOD_BPSK40;
        end else if (mode_code == CTX_M_OQ100) begin
            mod_sel = CTX_MOD_OQ100;
        end else if (mode_code == CTX_M_OQSIN250) begin
            mod_sel = CTX_MOD_OQSIN250;
        end else if (mode_code == CTX_M_OQRC250) begin
            mod_sel = CTX_MOD_OQRC250;
        end else if (mode_code == CTX_M_CW_NARROW) begin
            mode_cw = 1'b1; // 0.1 MHz tone via the 400 kbit/s setting
            mod_sel = CTX_MOD_OQ400;
        end else if (mode_code == CTX_M_CW_WIDE) begin
            mode_cw = 1'b1; // 0.25 MHz tone via the 1000 kbit/s setting
            cw_wide = 1'b1;
            mod_sel = CTX_MOD_OQ1000;
        end else begin
            mode_ok = 1'b0; // No centre-frequency carrier code exists
        end
    end
endmodule

// File: hw/ctx_frame_buf.sv
// Frame buffer holding the header byte and payload for repetition
`timescale 1ns/1ps
module ctx_frame_buf
    import ctx_pkg::*;
#(
    parameter int DEPTH = 128,
    parameter int IW = 7
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic wr_first,
    input wire logic [7:0] wr_data,
    input wire logic [IW-1:0] rd_addr,
    output logic [7:0] rd_data,
    output logic [7:0] phr,
    output logic [7:0] first_payload
);
    typedef struct packed {
        logic [IW-1:0] wptr;
        logic [7:0] phr;
    } ctx_fb_st_t;

    ctx_fb_st_t st_reg;
    ctx_fb_st_t st_next;
    logic [7:0] mem [DEPTH];
    logic [IW-1:0] waddr;

    // First byte of a burst always lands at index zero as the header
    always_comb begin
        st_next = st_reg;
        waddr = wr_first ? '0 : st_reg.wptr;
        if (wr_en) begin
            st_next.wptr = IW'(waddr + 1'b1);
            if (wr_first) begin
                st_next.phr = wr_data;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Storage holds no reset; only written entries are ever read back
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[waddr] <= wr_data;
        end
    end

    assign rd_data = mem[rd_addr];
    assign first_payload = mem[1];
    assign phr = st_reg.phr;
endmodule

// File: hw/ctx_top.sv
// Continuous transmission test mode controller with its register port
`timescale 1ns/1ps
module ctx_top
    import ctx_pkg::*;
#(
    parameter int FB_DEPTH = 128,
    parameter int FB_IW = 7
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [CTX_AW-1:0] reg_addr,
    input wire logic [CTX_DW-1:0] reg_wdata,
    output logic [CTX_DW-1:0] reg_rdata,
    input wire logic fb_wr,
    input wire logic fb_first,
    input wire logic [7:0] fb_wdata,
    input wire logic pll_lock,
    output logic pll_enable,
    output logic test_active,
    output logic tx_active,
    output logic tx_cw,
    output logic tx_cw_wide,
    output logic tx_cw_upper,
    output logic [2:0] tx_mod_sel,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic tx_hdr,
    output logic [7:0] tx_data
);
    // Host-side view of the block:
    //   - Reads are registered and answer one cycle after the strobe; unmapped reads give zero.
    //   - Writes land on the strobe edge; the readback and flag registers drop them.
    //   - The lock flag is armed by mask bit zero and only while the synthesizer comes up.
    //   - Reading the flag register clears it, but a lock edge in that same cycle still sets it.
    //   - Lock input is edge detected, so a lock that simply stays high raises the flag once.
    //   - Unlock takes three keys in order; a stray value on the second enable restarts it.
    //   - Writes to the first enable register also restart the unlock sequence.
    //   - Writing zero to the second enable leaves test mode; a running stream stops at once.
    // Command register:
    //   - Every written command is stored for readback, taken or not.
    //   - Force-off works from any state and stops the stream at once.
    //   - Synthesizer-on is taken only from off.
    //   - Start is refused unless locked, unlocked, the mode code known and the length valid.
    // Stream side:
    //   - Two header beats carry the length byte; payload bytes follow in order.
    //   - Frame buffer index zero holds the header byte; payload byte n sits at index n plus one.
    //   - After the last payload byte the index wraps to payload byte zero, so the payload repeats with no end count.
    //   - A beat stands until the modulator takes it; a slow modulator only stretches the frame.
    //   - Mode, tone side and length are frozen at start; later mode writes wait for a restart.
    //   - Frame buffer writes are ignored while beats flow, so the frame cannot tear mid-run.
    // Tones:
    //   - The narrow carrier uses the 400 kbit/s setting, the wide one the 1000 kbit/s setting.
    //   - Bit seven of payload byte zero picks the upper or lower side of the channel centre.
    //   - No code places the carrier on the channel centre itself.
    // Reset: the mode register and second enable come up at their power-on codes.
    // Limitation: leaving test mode keeps the old frame in the buffer until it is overwritten.
    typedef struct packed {
        ctx_trx_t trx;
        ctx_ph_t ph;
        logic [7:0] cmd;
        logic [7:0] mode;
        logic [7:0] mask;
        logic [7:0] flags;
        logic [7:0] en1;
        logic [7:0] en2;
        logic stage;
        logic test_on;
        logic [6:0] len;
        logic [FB_IW-1:0] idx;
        logic [1:0] hdr_cnt;
        logic [7:0] data;
        logic hdr;
        logic cw;
        logic cw_wide;
        logic cw_upper;
        logic [2:0] mod_sel;
        logic lock_d;
        logic [7:0] rdata;
    } ctx_st_t;

    ctx_st_t st_reg;
    ctx_st_t st_next;
    // Hookups to the mode decoder and the frame buffer
    logic mode_ok;
    logic mode_cw;
    logic cw_wide;
    logic [2:0] mod_sel;
    logic [FB_IW-1:0] rd_addr;
    logic [7:0] rd_data;
    logic [7:0] phr;
    logic [7:0] first_payload;

    // Mode decoder works on the stored code; start samples its answer
    ctx_mode_dec u_dec (
        .mode_code(st_reg.mode),
        .mode_ok(mode_ok),
        .mode_cw(mode_cw),
        .cw_wide(cw_wide),
        .mod_sel(mod_sel)
    );

    // Frame buffer writes are gated off while the stream phase is busy
    ctx_frame_buf #(
        .DEPTH(FB_DEPTH),
        .IW(FB_IW)
    ) u_fb (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr_en(fb_wr && (st_reg.ph == CTX_PH_IDLE)),
        .wr_first(fb_first),
        .wr_data(fb_wdata),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .phr(phr),
        .first_payload(first_payload)
    );

    // Register decode, state machine and beat sequencing in one pass
    always_comb begin
        logic wr_hit;
        logic lock_rise;
        logic start_ok;
        logic [FB_IW-1:0] nidx;
        logic hdr_ok;
        logic arm_ok;
        logic beat_ok;
        wr_hit = 1'b0;
        hdr_ok = 1'b0;
        arm_ok = 1'b0;
        beat_ok = 1'b0;
        lock_rise = 1'b0;
        start_ok = 1'b0;
        nidx = '0;
        st_next = st_reg;
        rd_addr = FB_IW'(1);
        lock_rise = pll_lock && !st_reg.lock_d;
        st_next.lock_d = pll_lock;
        wr_hit = reg_wr;

        // Read data is registered so it is stable through the access
        if (reg_rd) begin
            if (reg_addr == CTX_A_STATE) begin
                case (st_reg.trx)
                    CTX_TS_TX: begin
                        st_next.rdata = CTX_S_BUSY_TX;
                    end
                    CTX_TS_PLL: begin
                        st_next.rdata = CTX_S_PLL;
                    end
                    default: begin
                        st_next.rdata = CTX_S_OFF;
                    end
                endcase
            end else if (reg_addr == CTX_A_CMD) begin
                st_next.rdata = st_reg.cmd;
            end else if (reg_addr == CTX_A_MODE) begin
                st_next.rdata = st_reg.mode;
            end else if (reg_addr == CTX_A_MASK) begin
                st_next.rdata = st_reg.mask;
            end else if (reg_addr == CTX_A_FLAGS) begin
                st_next.rdata = st_reg.flags;
                st_next.flags = CTX_R_ZERO; // Clear on read; a new lock below still wins
            end else if (reg_addr == CTX_A_EN2) begin
                st_next.rdata = st_reg.en2;
            end else if (reg_addr == CTX_A_EN1) begin
                st_next.rdata = st_reg.en1;
            end else begin
                st_next.rdata = CTX_R_ZERO;
            end
        end

        // Lock flag is latched only while the synthesizer is being brought up
        if (lock_rise && (st_reg.trx == CTX_TS_PLL) && st_reg.mask[CTX_LOCK_BIT]) begin
            st_next.flags[CTX_LOCK_BIT] = 1'b1;
        end

        // Register writes; read-only and unmapped addresses fall through untouched
        if (wr_hit) begin
            if (reg_addr == CTX_A_MODE) begin
                st_next.mode = reg_wdata;
            end else if (reg_addr == CTX_A_MASK) begin
                st_next.mask = reg_wdata;
            end else if (reg_addr == CTX_A_EN1) begin
                st_next.en1 = reg_wdata;
                st_next.stage = 1'b0;
            end else if (reg_addr == CTX_A_EN2) begin
                st_next.en2 = reg_wdata;
                // Key sequence: first key must stand in the other register
                if (reg_wdata == CTX_K_OFF) begin
                    st_next.test_on = 1'b0;
                    st_next.stage = 1'b0;
                    st_next.ph = CTX_PH_IDLE; // Disable stops output
                    if (st_reg.trx == CTX_TS_TX) begin
                        st_next.trx = CTX_TS_PLL;
                    end
                end else if ((reg_wdata == CTX_K_TWO) && (st_reg.en1 == CTX_K_ONE)) begin
                    st_next.stage = 1'b1;
                end else if ((reg_wdata == CTX_K_THREE) && st_reg.stage) begin
                    st_next.test_on = 1'b1;
                    st_next.stage = 1'b0;
                end else begin
                    st_next.stage = 1'b0;
                end
            end else if (reg_addr == CTX_A_CMD) begin
                st_next.cmd = reg_wdata;
                if (reg_wdata == CTX_C_FORCE_OFF) begin
                    st_next.trx = CTX_TS_OFF;
                    st_next.ph = CTX_PH_IDLE;
                end else if ((reg_wdata == CTX_C_PLL_ON) && (st_reg.trx == CTX_TS_OFF)) begin
                    st_next.trx = CTX_TS_PLL;
                end else if (reg_wdata == CTX_C_TX_START) begin
                    // Header must give a length of at least one with the top bit clear
                    hdr_ok = (phr[6:0] >= CTX_PHR_MIN) && !phr[7];
                    // Synthesizer locked and the unlock keys all taken
                    arm_ok = (st_reg.trx == CTX_TS_PLL) && pll_lock && st_reg.test_on;
                    start_ok = arm_ok && hdr_ok && mode_ok;
                end
            end
        end

        // Start latches mode, length and tone side for the whole run
        if (start_ok) begin
            st_next.trx = CTX_TS_TX;
            st_next.ph = CTX_PH_HDR;
            st_next.hdr_cnt = '0;
            st_next.hdr = 1'b1;
            st_next.data = phr;
            st_next.len = phr[6:0];
            st_next.idx = '0;
            st_next.cw = mode_cw;
            st_next.cw_wide = cw_wide;
            st_next.mod_sel = mod_sel;
            st_next.cw_upper = first_payload[CTX_UPPER_BIT];
        end

        // A disable or forced off in this cycle outranks the beat accepted with it
        beat_ok = tx_valid && tx_ready && (st_next.ph != CTX_PH_IDLE);

        // Two header beats, then payload wraps with no end count
        if (beat_ok) begin
            case (st_reg.ph)
                CTX_PH_HDR: begin
                    st_next.hdr_cnt = 2'(st_reg.hdr_cnt + 1'b1);
                    if (st_reg.hdr_cnt == CTX_HDR_LAST) begin
                        // Second header beat hands over to payload byte zero
                        st_next.ph = CTX_PH_DATA;
                        st_next.hdr = 1'b0;
                        st_next.idx = '0;
                        rd_addr = FB_IW'(1);
                        st_next.data = rd_data;
                    end
                end
                CTX_PH_DATA: begin
                    // Index counts payload bytes; the buffer holds them one slot up
                    nidx = FB_IW'(st_reg.idx + 1'b1);
                    if (nidx == FB_IW'(st_reg.len)) begin
                        nidx = '0; // Wrap, never stop
                    end
                    st_next.idx = nidx;
                    rd_addr = FB_IW'(nidx + 1'b1);
                    st_next.data = rd_data;
                end
                default: begin
                    st_next.ph = st_reg.ph;
                end
            endcase
        end
    end

    // Reset restores the mode and second enable registers to their power-on codes;
    // all other state, the stream phase included, clears to zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_reg <= '0;
            st_reg.trx <= CTX_TS_OFF;
            st_reg.ph <= CTX_PH_IDLE;
            st_reg.mode <= CTX_R_MODE;
            st_reg.en2 <= CTX_R_EN2;
        end else begin
            st_reg <= st_next;
        end
    end

    // Register side and synthesizer request, straight from the state register
    assign reg_rdata = st_reg.rdata;
    assign pll_enable = (st_reg.trx != CTX_TS_OFF);
    assign test_active = st_reg.test_on;

    // Run settings, frozen at start and held for the whole run
    assign tx_active = (st_reg.trx == CTX_TS_TX);
    assign tx_cw = st_reg.cw;
    assign tx_cw_wide = st_reg.cw_wide;
    assign tx_cw_upper = st_reg.cw_upper;
    assign tx_mod_sel = st_reg.mod_sel;

    // Stream beat: valid follows the phase, data and header mark are registered
    assign tx_valid = (st_reg.ph != CTX_PH_IDLE);
    assign tx_hdr = st_reg.hdr;
    assign tx_data = st_reg.data;
endmodule

// File: testbench/ctx_top_sva.sv
// Port checker for the continuous transmission controller
`timescale 1ns/1ps
module ctx_top_sva
    import ctx_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic reg_wr,
    input wire logic [CTX_AW-1:0] reg_addr,
    input wire logic [CTX_DW-1:0] reg_wdata,
    input wire logic pll_lock,
    input wire logic pll_enable,
    input wire logic test_active,
    input wire logic tx_active,
    input wire logic tx_cw,
    input wire logic tx_cw_wide,
    input wire logic [2:0] tx_mod_sel,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic tx_hdr,
    input wire logic [7:0] tx_data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Both header beats accepted with no host write in between
    sequence s_hdr_pair;
        $rose(tx_active) && tx_hdr && tx_ready && !reg_wr ##1 tx_hdr && tx_ready && !reg_wr;
    endsequence
    a_pll_on_cmd: assert property (reg_wr && reg_addr == CTX_A_CMD && reg_wdata == CTX_C_PLL_ON && !pll_enable
        |=> pll_enable) else $error("synthesizer not enabled");
    a_start_needs_lock: assert property ($rose(tx_active) |-> $past(pll_lock) && $past(test_active)
        && $past(reg_wr && reg_addr == CTX_A_CMD && reg_wdata == CTX_C_TX_START))
        else $error("transmit started without cause");
    a_first_hdr: assert property ($rose(tx_active) |-> tx_valid && tx_hdr) else $error("no header beat");
    a_hdr_two: assert property (s_hdr_pair |=> tx_valid && !tx_hdr) else $error("header beat count");
    a_stall_hold: assert property (tx_valid && !tx_ready && !reg_wr |=> tx_valid && $stable(tx_data)
        && $stable(tx_hdr)) else $error("beat changed while stalled");
    a_no_timeout: assert property (tx_active && !reg_wr |=> tx_active) else $error("transmit ended");
    a_disable_stop: assert property (reg_wr && reg_addr == CTX_A_EN2 && reg_wdata == CTX_K_OFF && tx_active
        |=> !tx_valid && !test_active && pll_enable) else $error("disable did not stop");
    a_cw_tone: assert property (tx_active && tx_cw |-> tx_mod_sel == (tx_cw_wide ? CTX_MOD_OQ1000 : CTX_MOD_OQ400))
        else $error("carrier modulation wrong");
    a_valid_unlocked: assert property (tx_valid |-> tx_active && test_active)
        else $error("beat outside test mode");
endmodule
bind ctx_top ctx_top_sva ctx_top_sva_inst (.clk, .sys_rst, .reg_wr, .reg_addr, .reg_wdata, .pll_lock,
    .pll_enable, .test_active, .tx_active, .tx_cw, .tx_cw_wide, .tx_mod_sel, .tx_valid, .tx_ready, .tx_hdr, .tx_data);

// File: testbench/ctx_rf_model.sv
// Synthesizer and modulator model on the transmit side
`timescale 1ns/1ps
module ctx_rf_model #(
    parameter int LOCK_DLY = 8
)
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pll_enable,
    input wire logic slow,
    output logic pll_lock,
    output logic tx_ready
);
    int lock_cnt = 0;
    int beat_cnt = 0;
    logic lock_q = 1'b0;
    // Lock settles a while after enable and is lost at once when disabled
    always @(posedge clk) begin
        if (sys_rst || !pll_enable) begin
            lock_cnt <= 0;
            lock_q <= 1'b0;
        end else if (lock_cnt < LOCK_DLY) begin
            lock_cnt <= lock_cnt + 1;
        end else begin
            lock_q <= 1'b1;
        end
    end
    // Slow mode accepts one beat in three to exercise stalls
    always @(posedge clk) begin
        beat_cnt <= beat_cnt + 1;
    end
    assign pll_lock = lock_q;
    assign tx_ready = !slow || (beat_cnt % 3 == 0);
endmodule

// File: testbench/ctx_top_tb.sv
// Bench running the test mode programming sequence in every mode
`timescale 1ns/1ps
module ctx_top_tb;
    import ctx_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [CTX_AW-1:0] reg_addr = 6'h00;
    logic [CTX_DW-1:0] reg_wdata = 8'h00;
    logic fb_wr = 1'b0;
    logic fb_first = 1'b0;
    logic [7:0] fb_wdata = 8'h00;
    logic slow = 1'b0;
    logic [7:0] reg_rdata, tx_data;
    logic pll_lock, pll_enable, test_active, tx_active, tx_cw, tx_cw_wide, tx_cw_upper, tx_valid, tx_ready, tx_hdr;
    logic [2:0] tx_mod_sel;
    logic [8:0] cap[$];
    logic [7:0] modes[7] = '{CTX_M_BPSK20, CTX_M_BPSK40, CTX_M_OQ100, CTX_M_OQSIN250, CTX_M_OQRC250,
        CTX_M_CW_NARROW, CTX_M_CW_WIDE};
    logic [2:0] mods[7] = '{CTX_MOD_BPSK20, CTX_MOD_BPSK40, CTX_MOD_OQ100, CTX_MOD_OQSIN250, CTX_MOD_OQRC250,
        CTX_MOD_OQ400, CTX_MOD_OQ1000};
    int lens[7] = '{1, 3, 5, 127, 2, 1, 1};
    logic [7:0] pays[7] = '{8'h10, 8'h20, 8'h30, 8'h00, 8'h40, 8'h00, 8'hff};
    // Output power register sits outside this block; address and field place are stand-ins
    localparam logic [5:0] PWR_ADDR = 6'h05;
    localparam logic [7:0] PWR_GAIN_TWO = 8'h02;
    int mismatches = 0;
    int n_tests = 0;
    ctx_top ctx_top_inst (.clk, .sys_rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .fb_wr, .fb_first,
        .fb_wdata, .pll_lock, .pll_enable, .test_active, .tx_active, .tx_cw, .tx_cw_wide, .tx_cw_upper,
        .tx_mod_sel, .tx_valid, .tx_ready, .tx_hdr, .tx_data);
    ctx_rf_model ctx_rf_model_inst (.clk, .sys_rst, .pll_enable, .slow, .pll_lock, .tx_ready);
    // 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end
    // Record every accepted beat
    always @(posedge clk) begin
        if (!sys_rst && tx_valid === 1'b1 && tx_ready === 1'b1) cap.push_back({tx_hdr, tx_data});
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Strobes rise on one falling edge and drop on the next, so no two requests share an edge
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [5:0] a);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
    endtask
    task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
        rd(a);
        chk(reg_rdata, exp);
    endtask
    task automatic fbw(input logic first, input logic [7:0] d);
        @(negedge clk);
        fb_wr = 1'b1;
        fb_first = first;
        fb_wdata = d;
        @(negedge clk);
        fb_wr = 1'b0;
    endtask
    task automatic do_reset();
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        cap.delete();
    endtask
    // Polls the flag register; a missing lock ends the run
    task automatic wait_lock();
        int k;
        k = 0;
        do begin
            rd(CTX_A_FLAGS);
            k++;
        end while (reg_rdata !== 8'h01 && k < 40);
        chk(reg_rdata, 8'h01);
        if (reg_rdata !== 8'h01) tally_and_finish();
    endtask
    // Full programming sequence, capture of the repeated frame, then disable
    task automatic run(input int i);
        int k;
        do_reset();
        slow = (i == 2 || i == 3);
        wr(CTX_A_MASK, 8'h01);
        wr(CTX_A_CMD, CTX_C_FORCE_OFF);
        if (i > 4) wr(PWR_ADDR, PWR_GAIN_TWO);
        if (i > 4) rdc(PWR_ADDR, 8'h00); // Not mapped here, so the block ignores it
        rdc(CTX_A_STATE, CTX_S_OFF);
        wr(CTX_A_EN1, CTX_K_ONE);
        wr(CTX_A_MODE, modes[i]);
        fbw(1'b1, 8'(lens[i]));
        for (k = 0; k < lens[i]; k++) fbw(1'b0, pays[i] + 8'(k));
        wr(CTX_A_EN2, CTX_K_TWO);
        wr(CTX_A_EN2, CTX_K_THREE);
        chk({7'h00, test_active}, 8'h01);
        wr(CTX_A_CMD, CTX_C_PLL_ON);
        wait_lock();
        wr(CTX_A_CMD, CTX_C_TX_START);
        rdc(CTX_A_STATE, CTX_S_BUSY_TX);
        chk({3'h0, tx_cw, tx_cw_wide, tx_mod_sel}, {3'h0, 1'(i > 4), 1'(i == 6), mods[i]});
        if (i > 4) chk({7'h00, tx_cw_upper}, {7'h00, pays[i][7]});
        k = 0;
        while (cap.size() < 2 * lens[i] + 3 && k < 2000) begin
            @(negedge clk);
            k++;
        end
        if (cap.size() < 2 * lens[i] + 3) begin
            mismatches++;
            tally_and_finish();
        end
        for (k = 0; k < 2 * lens[i] + 3; k++) begin
            chk({7'h00, cap[k][8]}, {7'h00, 1'(k < 2)});
            chk(cap[k][7:0], k < 2 ? 8'(lens[i]) : pays[i] + 8'((k - 2) % lens[i]));
        end
        chk({7'h00, tx_active}, 8'h01);
        wr(CTX_A_EN2, CTX_K_OFF);
        chk({6'h00, tx_valid, test_active}, 8'h00);
        rdc(CTX_A_STATE, CTX_S_PLL);
    endtask
    // Reset values, refusals, then every mode
    initial begin
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        rdc(CTX_A_MODE, CTX_R_MODE);
        rdc(CTX_A_EN2, CTX_R_EN2);
        rdc(CTX_A_MASK, CTX_R_ZERO);
        rdc(6'h3f, 8'h00);
        wr(CTX_A_FLAGS, 8'hff);
        rdc(CTX_A_FLAGS, 8'h00);
        wr(CTX_A_MASK, 8'h01);
        wr(CTX_A_EN1, CTX_K_ONE);
        wr(CTX_A_EN2, CTX_K_THREE);
        chk({7'h00, test_active}, 8'h00);
        fbw(1'b1, 8'h01);
        fbw(1'b0, 8'h55);
        wr(CTX_A_CMD, CTX_C_PLL_ON);
        wait_lock();
        wr(CTX_A_CMD, CTX_C_TX_START);
        chk({6'h00, tx_active, tx_valid}, 8'h00);
        for (int i = 0; i < 7; i++) run(i);
        tally_and_finish();
    end
endmodule
